// ==== lfc_pkg.sv ====
// Package: register map, field layout, reset values and loop constants for the lock loop
package lfc_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] LFC_ADDR_ENABLES   = 8'h74;
  localparam logic [7:0] LFC_ADDR_RATIO     = 8'h75;
  localparam logic [7:0] LFC_ADDR_FRACTION  = 8'h76;
  localparam logic [7:0] LFC_ADDR_INTEGER   = 8'h77;
  localparam logic [7:0] LFC_ADDR_REFSEL    = 8'h78;
  localparam logic [7:0] LFC_ADDR_STATUS    = 8'h7B;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int LFC_EN_LOOP_BIT    = 0;
  localparam int LFC_EN_OSC_BIT     = 1;
  localparam int LFC_EN_FRAC_BIT    = 2;
  localparam int LFC_OUTDIV_LSB     = 8;
  localparam int LFC_OUTDIV_MSB     = 13;
  localparam int LFC_RATE_LSB       = 4;
  localparam int LFC_RATE_MSB       = 6;
  localparam int LFC_FRATIO_LSB     = 0;
  localparam int LFC_FRATIO_MSB     = 2;
  localparam int LFC_INT_LSB        = 5;
  localparam int LFC_INT_MSB        = 14;
  localparam int LFC_GAIN_LSB       = 0;
  localparam int LFC_GAIN_MSB       = 3;
  localparam int LFC_PREDIV_LSB     = 3;
  localparam int LFC_PREDIV_MSB     = 4;
  localparam int LFC_SRC_LSB        = 0;
  localparam int LFC_SRC_MSB        = 1;
  localparam int LFC_ST_LOCK_BIT    = 0;
  localparam int LFC_ST_OSC_BIT     = 1;
  localparam int LFC_ST_REFOK_BIT   = 2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [2:0]  LFC_ENABLES_RST  = 3'h0;
  localparam logic [5:0]  LFC_OUTDIV_RST   = 6'h00;
  localparam logic [2:0]  LFC_RATE_RST     = 3'h0;
  localparam logic [2:0]  LFC_FRATIO_RST   = 3'h7;
  localparam logic [15:0] LFC_FRACTION_RST = 16'h0000;
  localparam logic [9:0]  LFC_INT_RST      = 10'h000;
  localparam logic [3:0]  LFC_GAIN_RST     = 4'h0;
  localparam logic [1:0]  LFC_PREDIV_RST   = 2'h0;
  localparam logic [1:0]  LFC_SRC_RST      = 2'h0;

  // ------------------------------------------------------------
  // Codes and loop constants
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LFC_SRC_MASTER = 2'b00,
    LFC_SRC_BIT    = 2'b01,
    LFC_SRC_FRAME  = 2'b10,
    LFC_SRC_NONE   = 2'b11
  } lfc_src_t;

  localparam logic [5:0]  LFC_OUTDIV_MIN   = 6'h03;
  localparam logic [3:0]  LFC_GAIN_MAX     = 4'h8;
  localparam int          LFC_ERR_SHIFT    = 12;
  localparam logic [31:0] LFC_FREQ_INIT    = 32'h0100_0000;
  localparam logic [31:0] LFC_FREQ_MAX     = 32'h8000_0000;
  localparam logic [31:0] LFC_LOCK_WINDOW  = 32'h0001_0000;

endpackage : lfc_pkg

// ==== lfc_tick_div.sv ====
// Programmable divider: one output pulse for every divisor input pulses
module lfc_tick_div
  import lfc_pkg::*;
#(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tickIn,
  input  wire logic [W-1:0] divisor,
  output logic              tickOut
);

  logic [W-1:0] count;

  // Count input pulses; a divisor of zero acts as one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count   <= '0;
      tickOut <= 1'b0;
    end else if (tickIn) begin
      if (divisor <= W'(1) || count >= divisor - W'(1)) begin
        count   <= '0;
        tickOut <= 1'b1;
      end else begin
        count   <= count + W'(1);
        tickOut <= 1'b0;
      end
    end else begin
      tickOut <= 1'b0;
    end
  end

endmodule : lfc_tick_div

// ==== lfc_lock_loop_config.sv ====
// Lock loop configuration registers with a digital frequency-locked oscillator
// Summary of operation
// - Control block runs at oscillator rate over code plus one, one to eight.
// - Ratio divider bits 2:0 reset 111, divide 1,2,4,8,16; 000 above 1MHz.
// - Sixteen-bit fraction multiplier in bits 15:0, top bit weighs one half.
// - Ten-bit integer multiplier in bits 14:5, bottom bit weighs one.
// - Loop gain bits 3:0 scale error by two to the code, up to 32768.
// - Pre-divider bits 4:3 divide by 1,2,4,8; source bits 1:0, 11 reserved.
// - Output rate is oscillator over output divider; codes 3 to 63 give 4 to 64.
module lfc_lock_loop_config
  import lfc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  output logic      [15:0] rdata,
  input  wire logic        masterClkPin,
  input  wire logic        bitClkPin,
  input  wire logic        frameClkPin,
  output logic             oscTick,
  output logic             loopOutTick,
  output logic             locked
);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [2:0]  enables;
  logic [5:0]  outputDivider;
  logic [2:0]  controlBlockRate;
  logic [2:0]  ratioDivider;
  logic [15:0] fractionMultiplier;
  logic [9:0]  integerMultiplier;
  logic [3:0]  loopGain;
  logic [1:0]  referencePrediv;
  logic [1:0]  referenceSource;
  logic        refSeen;

  wire logic loopEnable           = enables[LFC_EN_LOOP_BIT];
  wire logic loopOscillatorEnable = enables[LFC_EN_OSC_BIT];
  wire logic fractionalModeEnable = enables[LFC_EN_FRAC_BIT];

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enables            <= LFC_ENABLES_RST;
      outputDivider      <= LFC_OUTDIV_RST;
      controlBlockRate   <= LFC_RATE_RST;
      ratioDivider       <= LFC_FRATIO_RST;
      fractionMultiplier <= LFC_FRACTION_RST;
      integerMultiplier  <= LFC_INT_RST;
      loopGain           <= LFC_GAIN_RST;
      referencePrediv    <= LFC_PREDIV_RST;
      referenceSource    <= LFC_SRC_RST;
    end else if (wrStrobe) begin
      if (addr == LFC_ADDR_ENABLES) begin
        enables <= wdata[LFC_EN_FRAC_BIT:LFC_EN_LOOP_BIT];
      end else if (addr == LFC_ADDR_RATIO) begin
        outputDivider    <= wdata[LFC_OUTDIV_MSB:LFC_OUTDIV_LSB];
        controlBlockRate <= wdata[LFC_RATE_MSB:LFC_RATE_LSB];
        ratioDivider     <= wdata[LFC_FRATIO_MSB:LFC_FRATIO_LSB];
      end else if (addr == LFC_ADDR_FRACTION) begin
        fractionMultiplier <= wdata;
      end else if (addr == LFC_ADDR_INTEGER) begin
        integerMultiplier <= wdata[LFC_INT_MSB:LFC_INT_LSB];
        loopGain          <= wdata[LFC_GAIN_MSB:LFC_GAIN_LSB];
      end else if (addr == LFC_ADDR_REFSEL) begin
        referencePrediv <= wdata[LFC_PREDIV_MSB:LFC_PREDIV_LSB];
        referenceSource <= wdata[LFC_SRC_MSB:LFC_SRC_LSB];
      end
    end
  end

  // Register reads; data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rdStrobe) begin
      if (addr == LFC_ADDR_ENABLES) begin
        rdata <= {13'h0000, enables};
      end else if (addr == LFC_ADDR_RATIO) begin
        rdata <= {2'h0, outputDivider, 1'b0, controlBlockRate, 1'b0, ratioDivider};
      end else if (addr == LFC_ADDR_FRACTION) begin
        rdata <= fractionMultiplier;
      end else if (addr == LFC_ADDR_INTEGER) begin
        rdata <= {1'b0, integerMultiplier, 1'b0, loopGain};
      end else if (addr == LFC_ADDR_REFSEL) begin
        rdata <= {11'h000, referencePrediv, 1'b0, referenceSource};
      end else if (addr == LFC_ADDR_STATUS) begin
        rdata <= {13'h0000, refSeen, loopOscillatorEnable, locked};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Reference pin synchronisers and source select
  // ------------------------------------------------------------
  logic [2:0] pinSync1;
  logic [2:0] pinSync2;
  logic [2:0] pinSync3;
  logic [2:0] pinLevel;
  logic       refLevelDly;
  logic       refLevel;
  logic       refRise;

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync1 <= 3'h0;
      pinSync2 <= 3'h0;
      pinSync3 <= 3'h0;
      pinLevel <= 3'h0;
    end else begin
      pinSync1 <= {frameClkPin, bitClkPin, masterClkPin};
      pinSync2 <= pinSync1;
      pinSync3 <= pinSync2;
      pinLevel <= (pinSync2 & pinSync3) | (pinLevel & (pinSync2 ^ pinSync3));
    end
  end

  // Source select; the reserved code gives no reference at all
  always_comb begin
    case (lfc_src_t'(referenceSource))
      LFC_SRC_MASTER: refLevel = pinLevel[0];
      LFC_SRC_BIT:    refLevel = pinLevel[1];
      LFC_SRC_FRAME:  refLevel = pinLevel[2];
      default:        refLevel = 1'b0;
    endcase
  end

  // Rising edge of the chosen reference
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refLevelDly <= 1'b0;
    end else begin
      refLevelDly <= refLevel;
    end
  end
  assign refRise = refLevel & ~refLevelDly;

  // ------------------------------------------------------------
  // Dividers: reference pre-divider, control rate, output divider
  // ------------------------------------------------------------
  logic       refTick;
  logic       ctrlTick;
  logic [6:0] prediv;
  logic [6:0] ctrlDiv;
  logic [6:0] outDiv;

  assign prediv  = 7'(1) << referencePrediv;
  assign ctrlDiv = 7'(controlBlockRate) + 7'h01;
  assign outDiv  = 7'(outputDivider) + 7'h01;

  lfc_tick_div #(.W(7)) u_prediv (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (refRise),
    .divisor (prediv),
    .tickOut (refTick)
  );

  lfc_tick_div #(.W(7)) u_ctrl_div (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (oscTick),
    .divisor (ctrlDiv),
    .tickOut (ctrlTick)
  );

  // Reserved output codes keep the output still
  lfc_tick_div #(.W(7)) u_out_div (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (oscTick & (outputDivider >= LFC_OUTDIV_MIN)),
    .divisor (outDiv),
    .tickOut (loopOutTick)
  );

  // ------------------------------------------------------------
  // Oscillator and frequency loop
  // ------------------------------------------------------------
  logic        [31:0] phaseAcc;
  logic        [31:0] freqWord;
  logic        [15:0] oscCount;
  logic        [2:0]  ratioShift;
  logic        [29:0] target;
  logic signed [47:0] errNow;
  logic signed [47:0] errHeld;
  logic               errPending;
  logic signed [47:0] next_freq;

  // Phase accumulator; its carry is one oscillator cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phaseAcc <= 32'h0000_0000;
      oscTick  <= 1'b0;
    end else if (loopOscillatorEnable) begin
      {oscTick, phaseAcc} <= {1'b0, phaseAcc} + {1'b0, freqWord};
    end else begin
      oscTick <= 1'b0;
    end
  end

  // Ratio code to shift; 1XX all give sixteen
  always_comb begin
    if (ratioDivider[2]) begin
      ratioShift = 3'h4;
    end else begin
      ratioShift = ratioDivider;
    end
  end

  // Oscillator cycles wanted per divided reference cycle, 16 fraction bits
  assign target = 30'({integerMultiplier,
                       fractionalModeEnable ? fractionMultiplier : 16'h0000}) << ratioShift;
  assign errNow = 48'(target) - 48'({oscCount, 16'h0000});

  // Count oscillator cycles over one divided reference period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oscCount   <= 16'h0000;
      errHeld    <= 48'sh0;
      errPending <= 1'b0;
      locked     <= 1'b0;
      refSeen    <= 1'b0;
    end else if (refTick) begin
      oscCount   <= 16'h0000;
      errHeld    <= errNow;
      errPending <= loopEnable;
      refSeen    <= 1'b1;
      // Signed window; an unsigned bound would never let a small error pass
      locked     <= loopEnable && (errNow < $signed(48'(LFC_LOCK_WINDOW)))
                    && (errNow > -$signed(48'(LFC_LOCK_WINDOW)));
    end else begin
      if (oscTick && oscCount != 16'hFFFF) begin
        oscCount <= oscCount + 16'h0001;
      end
      if (ctrlTick) begin
        errPending <= 1'b0;
      end
      if (!loopEnable) begin
        locked <= 1'b0;
      end
    end
  end

  // Error scaled by the gain, applied once per divided reference period at the next control block tick
  always_comb begin
    next_freq = $signed(48'(freqWord)) + ((errHeld <<< loopGain) >>> LFC_ERR_SHIFT);
    if (next_freq < 48'sh1) begin
      next_freq = 48'sh1;
    end else if (next_freq > $signed(48'(LFC_FREQ_MAX))) begin
      next_freq = 48'(LFC_FREQ_MAX);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freqWord <= LFC_FREQ_INIT;
    end else if (ctrlTick && errPending && loopEnable) begin
      freqWord <= next_freq[31:0];
    end
  end

endmodule : lfc_lock_loop_config

// ==== lfc_lock_loop_config_chk.sv ====
// Checker: bus answers and tick behaviour of the lock loop configuration block
module lfc_lock_loop_config_chk
  import lfc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wrStrobe,
  input wire logic        rdStrobe,
  input wire logic [15:0] rdata,
  input wire logic        masterClkPin,
  input wire logic        bitClkPin,
  input wire logic        frameClkPin,
  input wire logic        oscTick,
  input wire logic        loopOutTick,
  input wire logic        locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Write then immediate read of one address
  // ------------------------------------------------------------
  sequence wrRd(logic [7:0] a);
    wrStrobe && addr == a ##1 rdStrobe && addr == a;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_ratio_fields: assert property (
    wrRd(LFC_ADDR_RATIO) |=> rdata == ($past(wdata, 2) & 16'h3F77))
    else $error("ratio register readback wrong");
  chk_fraction_word: assert property (
    wrRd(LFC_ADDR_FRACTION) |=> rdata == $past(wdata, 2))
    else $error("fraction register readback wrong");
  chk_integer_gain: assert property (
    wrRd(LFC_ADDR_INTEGER) |=> rdata == ($past(wdata, 2) & 16'h7FEF))
    else $error("integer register readback wrong");
  chk_refsel_fields: assert property (
    wrRd(LFC_ADDR_REFSEL) |=> rdata == ($past(wdata, 2) & 16'h001B))
    else $error("reference select readback wrong");
  chk_read_idle: assert property (
    !rdStrobe |=> rdata == 16'h0000)
    else $error("read data without a read");
  chk_unmapped_zero: assert property (
    rdStrobe && !(addr inside {[8'h74:8'h78], 8'h7B}) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_osc_pulse: assert property (
    oscTick |=> !oscTick)
    else $error("oscillator tick longer than one cycle");
  chk_out_spacing: assert property (
    loopOutTick |=> !loopOutTick [*3])
    else $error("output ticks too close");
  chk_unlock_off: assert property (
    wrStrobe && addr == LFC_ADDR_ENABLES && !wdata[LFC_EN_LOOP_BIT] |-> ##[1:4] !locked)
    else $error("locked stays with loop disabled");
endmodule : lfc_lock_loop_config_chk

bind lfc_lock_loop_config lfc_lock_loop_config_chk chk_u (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
  .rdStrobe(rdStrobe), .rdata(rdata), .masterClkPin(masterClkPin),
  .bitClkPin(bitClkPin), .frameClkPin(frameClkPin), .oscTick(oscTick),
  .loopOutTick(loopOutTick), .locked(locked));

// ==== tb.sv ====
// Testbench: register access and loop frequency checks for the lock loop block
module tb
  import lfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wrStrobe, rdStrobe, masterClkPin, refOn;
  logic [2:0]  pinOn;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic        oscTick, loopOutTick, locked;
  int          mismatches, tests_run, refCnt, nOsc, nOut;
  logic [15:0] mask [7] = '{16'h0007, 16'h3F77, 16'hFFFF, 16'h7FEF, 16'h001B,
                            16'h0000, 16'h0002};
  logic [7:0]  regAddr [7] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7B};

  lfc_lock_loop_config dut_u (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdata(rdata), .masterClkPin(masterClkPin & pinOn[0]),
    .bitClkPin(masterClkPin & pinOn[1]), .frameClkPin(masterClkPin & pinOn[2]),
    .oscTick(oscTick),
    .loopOutTick(loopOutTick), .locked(locked));

  // Clock and 40-cycle reference, gated onto each pin by pinOn
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (refOn) begin
      refCnt <= (refCnt == 19) ? 0 : refCnt + 1;
      if (refCnt == 19) masterClkPin <= ~masterClkPin;
    end
  end

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cnt(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("[FAIL] %0t tick count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : cnt

  // Single write, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr <= a; wdata <= d; wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read with optional write in the cycle just before
  task automatic acc(input logic doWr, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] exp);
    addr <= a; wdata <= d;
    if (doWr) begin
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
    end
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    @(negedge clk);
    cmp(rdata, exp);
    @(posedge clk);
  endtask : acc

  // Count oscillator and output ticks over 800 cycles
  task automatic meas;
    nOsc = 0; nOut = 0;
    repeat (800) begin
      @(negedge clk);
      nOsc += (oscTick === 1'b1);
      nOut += (loopOutTick === 1'b1);
    end
    @(posedge clk);
  endtask : meas

  // Wait for lock, then let the loop settle further
  task automatic wait_lock(input int settle);
    int i;
    repeat (100) @(posedge clk);
    for (i = 0; i < 40000 && locked !== 1'b1; i++) @(posedge clk);
    cnt(int'(locked === 1'b1), 1, 1);
    if (locked !== 1'b1) end_of_test();
    repeat (settle) @(posedge clk);
  endtask : wait_lock

  initial begin
    clk = 0; rst = 1; addr = 0; wdata = 0; wrStrobe = 0; rdStrobe = 0;
    masterClkPin = 0; refOn = 0; refCnt = 0; mismatches = 0; tests_run = 0;
    pinOn = 3'b010;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, unmapped holes included
    for (int a = 8'h74; a <= 8'h7B; a++) acc(0, 8'(a), 0, (a == 8'h75) ? 16'h0007 : 0);
    // All-ones write then back-to-back read, masked by field layout
    foreach (regAddr[i]) acc(1, regAddr[i], 16'hFFFF, mask[i]);
    // Oscillator first, then multipliers, then loop
    wr(LFC_ADDR_ENABLES, 16'h0006);
    // Only the bit clock pin toggles: master and frame selections see no edge
    refOn <= 1'b1;
    wr(LFC_ADDR_REFSEL, 16'h0000);
    repeat (100) @(posedge clk);
    acc(0, LFC_ADDR_STATUS, 0, 16'h0002);
    wr(LFC_ADDR_REFSEL, 16'h0002);
    repeat (100) @(posedge clk);
    acc(0, LFC_ADDR_STATUS, 0, 16'h0002);
    wr(LFC_ADDR_REFSEL, 16'h0001);
    repeat (100) @(posedge clk);
    acc(0, LFC_ADDR_STATUS, 0, 16'h0006);
    pinOn <= 3'b001;
    wr(LFC_ADDR_RATIO, 16'h0300);
    wr(LFC_ADDR_FRACTION, 16'h8000);
    // Gain raised above default so the loop settles within the run
    wr(LFC_ADDR_INTEGER, 16'h008F);
    wr(LFC_ADDR_REFSEL, 16'h0000);
    wr(LFC_ADDR_ENABLES, 16'h0007);
    wait_lock(26000);
    meas();
    cnt(nOsc, 87, 93);
    cnt(nOut, 20, 24);
    // Ratio x2 and a reserved output divider
    wr(LFC_ADDR_RATIO, 16'h0201);
    wait_lock(22000);
    meas();
    cnt(nOsc, 175, 185);
    cnt(nOut, 0, 0);
    // Reserved source holds the frequency
    wr(LFC_ADDR_REFSEL, 16'h0003);
    meas();
    cnt(nOsc, 175, 185);
    wr(LFC_ADDR_ENABLES, 16'h0006);
    repeat (5) @(posedge clk);
    cmp({15'h0, locked}, 16'h0000);
    // Gain back to its default times-one setting
    acc(1, LFC_ADDR_INTEGER, 16'h0080, 16'h0080);
    end_of_test();
  end
endmodule : tb
